// *** verilog/shift_exec_pkg.sv ***
// shared constants, register map and carrier types for the shift/move/indirect datapath
package shift_exec_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // apb register map, byte addresses of aligned 32-bit words
    localparam int APB_AW = 12;
    localparam logic [APB_AW-1:0] ADDR_CMD = 12'h000;
    localparam logic [APB_AW-1:0] ADDR_ACC = 12'h004;
    localparam logic [APB_AW-1:0] ADDR_STATUS = 12'h008;
    localparam logic [APB_AW-1:0] ADDR_PTR0 = 12'h00c;
    localparam logic [APB_AW-1:0] ADDR_PTR1 = 12'h010;

    // status register bit positions
    localparam int ST_CARRY_BIT = 0;
    localparam int ST_ZERO_BIT = 1;
    localparam int ST_BUSY_BIT = 2;

    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [15:0] PTR_RST = 16'h0000;

    // file addresses that name the indirect window of each pointer
    localparam logic [6:0] WIN0_ADDR = 7'h00;
    localparam logic [6:0] WIN1_ADDR = 7'h01;

    ////////////////////////////////////////////////////////////////////////////////
    // operation and pointer update encodings
    typedef enum logic [1:0] {
        OP_SHIFT = 2'b00,
        OP_COPY = 2'b01,
        OP_INDIRECT = 2'b10,
        OP_RESERVED = 2'b11
    } op_t;

    typedef enum logic [1:0] {
        UPD_PRE_INC = 2'b00,
        UPD_PRE_DEC = 2'b01,
        UPD_POST_INC = 2'b10,
        UPD_POST_DEC = 2'b11
    } pointer_update_code_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_WAIT = 2'b10,
        ST_DATA = 2'b11
    } state_t;

    // command word layout, lsb last
    typedef struct packed {
        logic [8:0] pad_hi;
        logic [6:0] file_addr;
        logic [1:0] pad_mid;
        logic [5:0] offset;
        logic pad_lo;
        logic relative;
        pointer_update_code_t upd;
        logic ptr_sel;
        logic dest;
        op_t op;
    } cmd_t;

    // one request to the data memory
    typedef struct packed {
        logic en;
        logic we;
        logic [15:0] addr;
        logic [7:0] wdata;
    } mem_req_t;

endpackage

// *** verilog/pointer_step.sv ***
// pointer arithmetic: effective address and updated pointer for one pointer register
module pointer_step (
    input wire logic [15:0] ptr,
    input wire shift_exec_pkg::pointer_update_code_t upd,
    input wire logic relative,
    input wire logic [5:0] offset,
    output wire logic [15:0] eff_addr,
    output wire logic [15:0] next_ptr
);

    // 16-bit sums wrap naturally at both ends
    wire logic [15:0] plus_one = ptr + 16'h0001;
    wire logic [15:0] minus_one = ptr - 16'h0001;
    wire logic [15:0] off_ext = {{10{offset[5]}}, offset};
    wire logic [15:0] rel_addr = ptr + off_ext;

    // pre modes move the address, post modes use the pointer as it stands
    assign eff_addr = relative ? rel_addr :
                      (upd == shift_exec_pkg::UPD_PRE_INC) ? plus_one :
                      (upd == shift_exec_pkg::UPD_PRE_DEC) ? minus_one : ptr;

    // code bit 0 marks a decrement; relative addressing leaves the pointer alone
    assign next_ptr = relative ? ptr : (upd[0] ? minus_one : plus_one);

endmodule

// *** verilog/shift_move_indirect_exec.sv ***
// execution datapath for logical right shift, file copy and indirect load, with apb registers
module shift_move_indirect_exec (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [shift_exec_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output shift_exec_pkg::mem_req_t mem_req,
    input wire logic [7:0] mem_rdata
);

    ////////////////////////////////////////////////////////////////////////////////
    // state
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic [31:0] prdata_ff, nxt_prdata;
    shift_exec_pkg::state_t state_ff, nxt_state;
    shift_exec_pkg::cmd_t cmd_ff, nxt_cmd;
    shift_exec_pkg::mem_req_t mem_req_ff, nxt_mem_req;
    logic [7:0] acc_ff, nxt_acc;
    logic carry_ff, nxt_carry;
    logic zero_ff, nxt_zero;
    logic [15:0] ptr0_ff, nxt_ptr0;
    logic [15:0] ptr1_ff, nxt_ptr1;

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode; the answer comes one cycle into the access phase
    wire logic acc_phase = psel & penable;
    wire logic first_access = acc_phase & ~pready_ff;
    wire logic take = acc_phase & pready_ff;
    wire logic busy = (state_ff != shift_exec_pkg::ST_IDLE);
    wire logic hit_cmd = (paddr == shift_exec_pkg::ADDR_CMD);
    wire logic hit_acc = (paddr == shift_exec_pkg::ADDR_ACC);
    wire logic hit_status = (paddr == shift_exec_pkg::ADDR_STATUS);
    wire logic hit_ptr0 = (paddr == shift_exec_pkg::ADDR_PTR0);
    wire logic hit_ptr1 = (paddr == shift_exec_pkg::ADDR_PTR1);
    wire logic mapped = hit_cmd | hit_acc | hit_status | hit_ptr0 | hit_ptr1;
    wire shift_exec_pkg::cmd_t wr_cmd = shift_exec_pkg::cmd_t'(pwdata);

    // writes to live state are refused while a command runs, so no update can race the datapath
    wire logic busy_refuse = pwrite & busy & (hit_cmd | hit_acc | hit_ptr0 | hit_ptr1);
    wire logic bad_op = pwrite & hit_cmd & (wr_cmd.op == shift_exec_pkg::OP_RESERVED);
    wire logic bus_err = ~mapped | busy_refuse | bad_op;
    wire logic wr_ok = take & pwrite & ~bus_err;
    wire logic start = wr_ok & hit_cmd;

    // read mux, unused bits read as zero except the command pad fields, which read back as written
    wire logic [31:0] status_word = {29'h0, busy, zero_ff, carry_ff};
    wire logic [31:0] rd_mux = hit_cmd ? 32'(cmd_ff) :
                               hit_acc ? {24'h0, acc_ff} :
                               hit_status ? status_word :
                               hit_ptr0 ? {16'h0, ptr0_ff} :
                               hit_ptr1 ? {16'h0, ptr1_ff} : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // pointer arithmetic, one unit per pointer
    wire logic [15:0] eff0, eff1, next0, next1;

    pointer_step u_step0 (
        .ptr(ptr0_ff),
        .upd(cmd_ff.upd),
        .relative(cmd_ff.relative),
        .offset(cmd_ff.offset),
        .eff_addr(eff0),
        .next_ptr(next0)
    );

    pointer_step u_step1 (
        .ptr(ptr1_ff),
        .upd(cmd_ff.upd),
        .relative(cmd_ff.relative),
        .offset(cmd_ff.offset),
        .eff_addr(eff1),
        .next_ptr(next1)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // operand address and result selection
    wire logic is_shift = (cmd_ff.op == shift_exec_pkg::OP_SHIFT);
    wire logic is_copy = (cmd_ff.op == shift_exec_pkg::OP_COPY);
    wire logic is_ind = (cmd_ff.op == shift_exec_pkg::OP_INDIRECT);
    wire logic [15:0] sel_ptr = cmd_ff.ptr_sel ? ptr1_ff : ptr0_ff;
    wire logic [15:0] off_ext = {{10{cmd_ff.offset[5]}}, cmd_ff.offset};
    wire logic [15:0] sel_eff = cmd_ff.ptr_sel ? eff1 : eff0;
    wire logic names_win0 = (cmd_ff.file_addr == shift_exec_pkg::WIN0_ADDR);
    wire logic names_win1 = (cmd_ff.file_addr == shift_exec_pkg::WIN1_ADDR);
    // the window is only an address redirect, nothing is stored for it
    wire logic [15:0] win_addr = names_win1 ? ptr1_ff : ptr0_ff;
    wire logic [15:0] file_addr = (names_win0 | names_win1) ? win_addr : {9'h000, cmd_ff.file_addr};
    wire logic [15:0] op_addr = is_ind ? sel_eff : file_addr;

    wire logic [7:0] shift_res = {1'b0, mem_rdata[7:1]};
    wire logic [7:0] result = is_shift ? shift_res : mem_rdata;
    wire logic res_zero = (result == 8'h00);
    wire logic finish = (state_ff == shift_exec_pkg::ST_DATA);
    wire logic to_acc = is_ind | ~cmd_ff.dest;
    wire logic write_back = ~is_ind & cmd_ff.dest;

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer: latch command, issue read, wait one cycle for data, finish
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            shift_exec_pkg::ST_IDLE: begin
                if (start) begin
                    nxt_state = shift_exec_pkg::ST_ADDR;
                end
            end
            shift_exec_pkg::ST_ADDR: nxt_state = shift_exec_pkg::ST_WAIT;
            shift_exec_pkg::ST_WAIT: nxt_state = shift_exec_pkg::ST_DATA;
            shift_exec_pkg::ST_DATA: nxt_state = shift_exec_pkg::ST_IDLE;
            default: nxt_state = shift_exec_pkg::ST_IDLE;
        endcase
    end

    // memory request: read in the address state, optional write back on finish
    always_comb begin
        nxt_mem_req = '0;
        if (state_ff == shift_exec_pkg::ST_ADDR) begin
            nxt_mem_req.en = 1'b1;
            nxt_mem_req.addr = op_addr;
        end else if (finish & write_back) begin
            nxt_mem_req.en = 1'b1;
            nxt_mem_req.we = 1'b1;
            nxt_mem_req.addr = op_addr;
            nxt_mem_req.wdata = result;
        end
    end

    // accumulator, flags and pointers; software writes only land while idle
    always_comb begin
        nxt_acc = acc_ff;
        nxt_carry = carry_ff;
        nxt_zero = zero_ff;
        nxt_ptr0 = ptr0_ff;
        nxt_ptr1 = ptr1_ff;
        nxt_cmd = cmd_ff;
        if (start) begin
            nxt_cmd = wr_cmd;
        end
        if (wr_ok & hit_acc) begin
            nxt_acc = pwdata[7:0];
        end
        if (wr_ok & hit_ptr0) begin
            nxt_ptr0 = pwdata[15:0];
        end
        if (wr_ok & hit_ptr1) begin
            nxt_ptr1 = pwdata[15:0];
        end
        if (finish) begin
            nxt_zero = res_zero;
            if (to_acc) begin
                nxt_acc = result;
            end
            if (is_shift) begin
                nxt_carry = mem_rdata[0];
            end
            if (is_ind & ~cmd_ff.ptr_sel) begin
                nxt_ptr0 = next0;
            end
            if (is_ind & cmd_ff.ptr_sel) begin
                nxt_ptr1 = next1;
            end
        end
    end

    // bus answer: pready, error and read data stand for exactly one cycle
    assign nxt_pready = first_access;
    assign nxt_pslverr = first_access & bus_err;
    assign nxt_prdata = (first_access & ~pwrite) ? rd_mux : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= shift_exec_pkg::ST_IDLE;
            cmd_ff <= '0;
            mem_req_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cmd_ff <= nxt_cmd;
            mem_req_ff <= nxt_mem_req;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_ff <= shift_exec_pkg::ACC_RST;
            carry_ff <= 1'b0;
            zero_ff <= 1'b0;
            ptr0_ff <= shift_exec_pkg::PTR_RST;
            ptr1_ff <= shift_exec_pkg::PTR_RST;
        end else begin
            acc_ff <= nxt_acc;
            carry_ff <= nxt_carry;
            zero_ff <= nxt_zero;
            ptr0_ff <= nxt_ptr0;
            ptr1_ff <= nxt_ptr1;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign mem_req = mem_req_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire logic addr_ind = (state_ff == shift_exec_pkg::ST_ADDR) & is_ind;

    property p_shift_value;
        finish && is_shift && to_acc |=> acc_ff == {1'b0, $past(mem_rdata[7:1])} && carry_ff == $past(mem_rdata[0]);
    endproperty
    a_shift_value: assert property (p_shift_value) else $error("shift result or carry wrong");

    property p_shift_msb;
        finish && is_shift && write_back |=> mem_req_ff.en && mem_req_ff.we && !mem_req_ff.wdata[7];
    endproperty
    a_shift_msb: assert property (p_shift_msb) else $error("shift write back msb not zero");

    property p_dest_acc;
        finish && !is_ind && !cmd_ff.dest |=> !mem_req_ff.en && acc_ff == $past(result);
    endproperty
    a_dest_acc: assert property (p_dest_acc) else $error("destination 0 did not go to accumulator");

    property p_copy_back;
        finish && is_copy && cmd_ff.dest |=> mem_req_ff.we && mem_req_ff.wdata == $past(mem_rdata)
            && mem_req_ff.addr == $past(op_addr) && acc_ff == $past(acc_ff);
    endproperty
    a_copy_back: assert property (p_copy_back) else $error("copy write back wrong");

    property p_copy_zero;
        finish && is_copy |=> zero_ff == ($past(mem_rdata) == 8'h00);
    endproperty
    a_copy_zero: assert property (p_copy_zero) else $error("copy zero flag wrong");

    property p_shift_zero;
        finish && is_shift |=> zero_ff == ($past(mem_rdata[7:1]) == 7'h00);
    endproperty
    a_shift_zero: assert property (p_shift_zero) else $error("shift zero flag wrong");

    property p_ind_load;
        finish && is_ind |=> acc_ff == $past(mem_rdata) && zero_ff == ($past(mem_rdata) == 8'h00);
    endproperty
    a_ind_load: assert property (p_ind_load) else $error("indirect load value or zero flag wrong");

    property p_pre_inc;
        addr_ind && !cmd_ff.relative && cmd_ff.upd == shift_exec_pkg::UPD_PRE_INC
            |=> mem_req_ff.en && mem_req_ff.addr == $past(sel_ptr) + 16'h0001;
    endproperty
    a_pre_inc: assert property (p_pre_inc) else $error("pre-increment address wrong");

    property p_pre_dec;
        addr_ind && !cmd_ff.relative && cmd_ff.upd == shift_exec_pkg::UPD_PRE_DEC
            |=> mem_req_ff.en && mem_req_ff.addr == $past(sel_ptr) - 16'h0001;
    endproperty
    a_pre_dec: assert property (p_pre_dec) else $error("pre-decrement address wrong");

    property p_rel_addr;
        addr_ind && cmd_ff.relative |=> mem_req_ff.addr == $past(sel_ptr) + $past(off_ext);
    endproperty
    a_rel_addr: assert property (p_rel_addr) else $error("relative address wrong");

    property p_post_dec;
        addr_ind && !cmd_ff.relative && cmd_ff.upd == shift_exec_pkg::UPD_POST_DEC
            |-> ##1 mem_req_ff.addr == $past(sel_ptr) ##2 sel_ptr == $past(sel_ptr, 3) - 16'h0001;
    endproperty
    a_post_dec: assert property (p_post_dec) else $error("post-decrement address or pointer wrong");

    // post modes read at the old pointer and only then step it
    property p_post_inc;
        addr_ind && !cmd_ff.relative && cmd_ff.upd == shift_exec_pkg::UPD_POST_INC
            |-> ##1 mem_req_ff.addr == $past(sel_ptr) ##2 sel_ptr == $past(sel_ptr, 3) + 16'h0001;
    endproperty
    a_post_inc: assert property (p_post_inc) else $error("post-increment address or pointer wrong");

    property p_rel_keep;
        addr_ind && cmd_ff.relative |-> ##3 sel_ptr == $past(sel_ptr, 3);
    endproperty
    a_rel_keep: assert property (p_rel_keep) else $error("relative mode changed the pointer");

    property p_wrap;
        finish && is_ind && !cmd_ff.relative && !cmd_ff.upd[0] && sel_ptr == 16'hffff |=> sel_ptr == 16'h0000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("pointer did not wrap to zero");

    // a decrement from the bottom must come round to the top, not stick at zero
    property p_wrap_down;
        finish && is_ind && !cmd_ff.relative && cmd_ff.upd[0] && sel_ptr == 16'h0000 |=> sel_ptr == 16'hffff;
    endproperty
    a_wrap_down: assert property (p_wrap_down) else $error("pointer did not wrap to the top");

    property p_window;
        (state_ff == shift_exec_pkg::ST_ADDR) && !is_ind && names_win1 |=> mem_req_ff.addr == $past(ptr1_ff);
    endproperty
    a_window: assert property (p_window) else $error("window access not redirected");

    property p_window0;
        (state_ff == shift_exec_pkg::ST_ADDR) && !is_ind && names_win0 |=> mem_req_ff.addr == $past(ptr0_ff);
    endproperty
    a_window0: assert property (p_window0) else $error("window 0 access not redirected");

    property p_sequence;
        start |=> state_ff == shift_exec_pkg::ST_ADDR ##1 mem_req_ff.en && !mem_req_ff.we ##2 !busy;
    endproperty
    a_sequence: assert property (p_sequence) else $error("command sequence wrong");

    c_shift_back: cover property (finish && is_shift && cmd_ff.dest);
    c_copy_zero: cover property (finish && is_copy && res_zero);
    c_ind_wrap: cover property (finish && is_ind && sel_ptr == 16'h0000 && cmd_ff.upd[0]);
    c_refused: cover property (take && busy_refuse);

endmodule

// *** dv/data_mem_model.sv ***
// behavioural data memory that answers the datapath's memory requests
module data_mem_model (
    input wire logic pclk,
    input wire shift_exec_pkg::mem_req_t mem_req,
    output logic [7:0] mem_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] store [0:65535];

    initial begin
        mem_rdata = 8'h3c;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data stands for one cycle only; afterwards the bus toggles each cycle, so stale data reads inverted one cycle later and comes back every other cycle
    always @(posedge pclk) begin
        if (mem_req.en && !mem_req.we) begin
            mem_rdata <= store[mem_req.addr];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
        if (mem_req.en && mem_req.we) begin
            store[mem_req.addr] <= mem_req.wdata;
        end
    end
endmodule

// *** dv/shift_move_indirect_exec_bench.sv ***
// self-checking bench for the shift, file copy and indirect load datapath
module shift_move_indirect_exec_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    shift_exec_pkg::mem_req_t mem_req;
    logic [7:0] mem_rdata;
    int err_total = 0;
    int num_checks = 0;
    logic [31:0] rd;
    logic er;
    logic held = 1'h0;

    shift_move_indirect_exec dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mem_req(mem_req), .mem_rdata(mem_rdata));

    data_mem_model mem_u (.pclk(pclk), .mem_req(mem_req), .mem_rdata(mem_rdata));

    ////////////////////////////////////////////////////////////////////////////////
    // checking and apb master
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // keep holds psel so the next setup follows at once; otherwise one idle cycle is inserted
    task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic keep);
        if (!held) @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        // no assumed wait count: only the watchdog ends a stuck transfer
        while (pready !== 1'h1) begin
            @(posedge pclk);
        end
        rd = prdata;
        er = pslverr;
        penable <= 1'h0;
        held = keep;
        if (!keep) psel <= 1'h0;
    endtask

    task wait_idle;
        do begin
            xfer(1'h0, shift_exec_pkg::ADDR_STATUS, 32'h0, 1'h0);
        end while (rd[2] !== 1'h0);
    endtask

    task run(input logic [31:0] c);
        xfer(1'h1, shift_exec_pkg::ADDR_CMD, c, 1'h0);
        chk("cmd error", 32'h0, {31'h0, er});
        wait_idle;
    endtask

    function automatic logic [31:0] cmd(input logic [1:0] op, input logic dst, input logic sel,
        input logic [1:0] upd, input logic rel, input logic [5:0] off, input logic [6:0] fa);
        return {9'h0, fa, 2'h0, off, 1'h0, rel, upd, sel, dst, op};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task refusals;
        xfer(1'h0, shift_exec_pkg::ADDR_ACC, 32'h0, 1'h0);
        chk("acc after reset", 32'h0, rd);
        xfer(1'h0, 12'h014, 32'h0, 1'h0);
        chk("unmapped read error", 32'h1, {31'h0, er});
        xfer(1'h1, 12'h014, 32'hff, 1'h0);
        chk("unmapped write error", 32'h1, {31'h0, er});
        xfer(1'h1, shift_exec_pkg::ADDR_CMD, cmd(2'h3, 1'h0, 1'h0, 2'h0, 1'h0, 6'h0, 7'h05), 1'h0);
        chk("reserved op error", 32'h1, {31'h0, er});
        xfer(1'h1, shift_exec_pkg::ADDR_STATUS, 32'h7, 1'h0);
        chk("status write error", 32'h0, {31'h0, er});
        mem_u.store[16'h0005] = 8'h81;
        // a write landing while busy must bounce and leave the shift result intact
        xfer(1'h1, shift_exec_pkg::ADDR_CMD, cmd(2'h0, 1'h0, 1'h0, 2'h0, 1'h0, 6'h0, 7'h05), 1'h1);
        xfer(1'h1, shift_exec_pkg::ADDR_ACC, 32'h77, 1'h0);
        chk("busy write error", 32'h1, {31'h0, er});
        wait_idle;
        chk("carry", 32'h1, {31'h0, rd[0]});
        xfer(1'h0, shift_exec_pkg::ADDR_ACC, 32'h0, 1'h0);
        chk("acc", 32'h40, rd);
    endtask

    task file_case(input logic [1:0] op, input logic dst, input logic [6:0] fa, input logic [15:0] a,
        input logic [7:0] v);
        logic [7:0] res;
        res = (op == 2'h0) ? {1'h0, v[7:1]} : v;
        mem_u.store[a] = v;
        xfer(1'h1, shift_exec_pkg::ADDR_ACC, 32'ha5, 1'h0);
        run(cmd(op, dst, 1'h0, 2'h0, 1'h0, 6'h0, fa));
        chk("zero flag", {31'h0, res == 8'h0}, {31'h0, rd[1]});
        if (op == 2'h0) chk("carry", {31'h0, v[0]}, {31'h0, rd[0]});
        xfer(1'h0, shift_exec_pkg::ADDR_ACC, 32'h0, 1'h0);
        chk("acc", dst ? 32'ha5 : {24'h0, res}, rd);
        if (dst) chk("file", {24'h0, res}, {24'h0, mem_u.store[a]});
    endtask

    task ind_case(input logic sel, input logic [15:0] p, input logic [1:0] upd, input logic rel,
        input logic [5:0] off, input logic [7:0] v);
        logic [15:0] a;
        logic [15:0] np;
        logic [11:0] pa;
        pa = sel ? shift_exec_pkg::ADDR_PTR1 : shift_exec_pkg::ADDR_PTR0;
        a = rel ? p + {{10{off[5]}}, off} : (upd == 2'h0 ? p + 16'h1 : (upd == 2'h1 ? p - 16'h1 : p));
        np = rel ? p : (upd[0] ? p - 16'h1 : p + 16'h1);
        // neighbours hold other data so a wrong address shows
        for (int i = -1; i < 2; i++) mem_u.store[p + i[15:0]] = ~v;
        mem_u.store[a] = v;
        xfer(1'h1, pa, {16'h0, p}, 1'h0);
        run(cmd(2'h2, 1'h0, sel, upd, rel, off, 7'h10));
        chk("zero flag", {31'h0, v == 8'h0}, {31'h0, rd[1]});
        xfer(1'h0, shift_exec_pkg::ADDR_ACC, 32'h0, 1'h0);
        chk("acc", {24'h0, v}, rd);
        xfer(1'h0, pa, 32'h0, 1'h0);
        chk("pointer", {16'h0, np}, rd);
    endtask

    task summarize;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // clock, watchdog and main sequence
    initial begin
        pclk = 1'h0;
        forever #2 pclk = ~pclk;
    end

    initial begin
        #200000;
        err_total++;
        summarize;
    end

    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        refusals;
        file_case(2'h0, 1'h0, 7'h20, 16'h0020, 8'hb5);
        file_case(2'h0, 1'h1, 7'h21, 16'h0021, 8'h01);
        file_case(2'h0, 1'h0, 7'h7f, 16'h007f, 8'h80);
        file_case(2'h1, 1'h0, 7'h22, 16'h0022, 8'hc3);
        file_case(2'h1, 1'h1, 7'h23, 16'h0023, 8'h00);
        xfer(1'h1, shift_exec_pkg::ADDR_PTR0, 32'h2222, 1'h0);
        file_case(2'h1, 1'h0, shift_exec_pkg::WIN0_ADDR, 16'h2222, 8'h9c);
        xfer(1'h0, shift_exec_pkg::ADDR_PTR0, 32'h0, 1'h0);
        chk("window pointer", 32'h2222, rd);
        xfer(1'h1, shift_exec_pkg::ADDR_PTR1, 32'h3333, 1'h0);
        file_case(2'h0, 1'h1, shift_exec_pkg::WIN1_ADDR, 16'h3333, 8'h03);
        xfer(1'h0, shift_exec_pkg::ADDR_PTR1, 32'h0, 1'h0);
        chk("window pointer", 32'h3333, rd);
        ind_case(1'h0, 16'h1234, 2'h0, 1'h0, 6'h0, 8'h5a);
        ind_case(1'h1, 16'h1234, 2'h1, 1'h0, 6'h0, 8'h00);
        ind_case(1'h0, 16'hffff, 2'h0, 1'h0, 6'h0, 8'h11);
        ind_case(1'h1, 16'h0000, 2'h3, 1'h0, 6'h0, 8'h22);
        ind_case(1'h0, 16'h0000, 2'h1, 1'h0, 6'h0, 8'h33);
        ind_case(1'h1, 16'hffff, 2'h2, 1'h0, 6'h0, 8'h44);
        ind_case(1'h0, 16'h0100, 2'h2, 1'h1, 6'h20, 8'h55);
        ind_case(1'h1, 16'h0100, 2'h0, 1'h1, 6'h1f, 8'h66);
        summarize;
    end
endmodule
